// file: inc/pdt_pkg.sv
// Shared types, tables and constants of the PCM/FM demodulation core.
// Assumes 12-bit signed I/Q samples at four samples per symbol.
package pdt_pkg;

	// ==========================================
	// Widths and sizes
	localparam int SAMPLE_W = 12;
	localparam int CW = 16;
	localparam int AW = 20;
	localparam int MW = 24;
	localparam int FIFO_W = 24;
	localparam int FIFO_D = 16;
	localparam int NUM_HYP = 16;
	localparam int NUM_PART = 4;
	localparam int SPS = 4;
	localparam int PROD_SHIFT = 11;

	// ==========================================
	// Carriers
	typedef struct packed
	{
		logic signed [SAMPLE_W-1:0] i;
		logic signed [SAMPLE_W-1:0] q;
	} pdt_iq_s;

	typedef struct packed
	{
		logic signed [CW-1:0] re;
		logic signed [CW-1:0] im;
	} pdt_cplx_s;

	typedef struct packed
	{
		logic signed [AW-1:0] re;
		logic signed [AW-1:0] im;
	} pdt_acc_s;

	typedef struct packed
	{
		logic [3:0] hyp;
		logic [MW-1:0] mag;
	} pdt_metric_s;

	// ==========================================
	// Cosine of index*pi/8, full scale 2047
	localparam logic [SAMPLE_W-1:0] COS_TBL [16] = '{
		12'h7ff, 12'h763, 12'h5a7, 12'h30f, 12'h000, 12'hcf1, 12'ha59, 12'h89d,
		12'h801, 12'h89d, 12'ha59, 12'hcf1, 12'h000, 12'h30f, 12'h5a7, 12'h763};
	localparam logic [3:0] SIN_OFS = 4'h4;

	// ==========================================
	// Timing loop lags and constants
	localparam int LAG_DIFF_HALF = 3;
	localparam int LAG_INPUT_HALF = 4;
	localparam int LAG_HALFBAND = 10;
	localparam int LAG_SAMPLES = (LAG_DIFF_HALF + LAG_INPUT_HALF + 1) / 2 + LAG_HALFBAND;
	localparam logic [1:0] STROBE_PHASE = 2'(LAG_SAMPLES % SPS);
	localparam int TED_SHIFT = 16;
	localparam logic signed [23:0] TED_THR = 24'sh004000;

	// ==========================================
	// Frequency loop constants
	localparam int AFC_AVG_SYMBOLS = 1024;
	localparam logic [9:0] AFC_LAST = 10'(AFC_AVG_SYMBOLS - 1);
	localparam int AFC_SHIFT = 8;

	// Multiply by j, so the real part of a*conj(j*b) is the phase term
	function automatic pdt_iq_s pdt_jrot(input pdt_iq_s a);
		pdt_iq_s r;
		r.i = -a.q;
		r.q = a.i;
		return r;
	endfunction

	// Rotate by q quarter turns
	function automatic pdt_acc_s pdt_qrot(input pdt_acc_s a, input logic [1:0] q);
		pdt_acc_s r;
		case (q)
			2'h1: r = '{re: -a.im, im: a.re};
			2'h2: r = '{re: -a.re, im: -a.im};
			2'h3: r = '{re: a.im, im: -a.re};
			default: r = a;
		endcase
		return r;
	endfunction

	// Quarter turns over one symbol for a bit pair
	function automatic logic [1:0] pdt_qturn(input logic [1:0] h);
		logic [1:0] r;
		case (h)
			2'h0: r = 2'h3;
			2'h3: r = 2'h1;
			default: r = 2'h0;
		endcase
		return r;
	endfunction

endpackage

// file: design/pdt_fifo.sv
// Sample FIFO with valid/ready on both sides.
// Assumes the depth is a power of two.
`timescale 1ns/1ns
module pdt_fifo #(
	parameter int W = pdt_pkg::FIFO_W,
	parameter int D = pdt_pkg::FIFO_D
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [W-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [W-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int PW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic [PW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];

	always_comb
	begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 1'b1;
		else if (pop & ~push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready_out <= (next_count != (PW+1)'(D));
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (ce_in && push)
			mem[wr_ptr] <= in_data_in;
	end
endmodule

// file: design/pdt_derot.sv
// De-rotation: a times the conjugate of b, scaled back to CW bits.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module pdt_derot (
	input wire pdt_pkg::pdt_iq_s a_in,
	input wire pdt_pkg::pdt_iq_s b_in,
	output pdt_pkg::pdt_cplx_s y_out
);
	logic signed [24:0] re_full;
	logic signed [24:0] im_full;

	assign re_full = 25'(a_in.i * b_in.i) + 25'(a_in.q * b_in.q);
	assign im_full = 25'(a_in.q * b_in.i) - 25'(a_in.i * b_in.q);
	assign y_out.re = 16'(re_full >>> pdt_pkg::PROD_SHIFT);
	assign y_out.im = 16'(im_full >>> pdt_pkg::PROD_SHIFT);
endmodule

// file: design/pdt_core.sv
// PCM/FM demodulation core: AFC, symbol timing, matched filter, detector.
// Assumes an upstream front end feeding baseband samples on this clock.
//
// Overview of operation
// - Timing loop acquires and tracks +/-50 ppm at 0 dB SNR or better.
// - Consecutive samples de-rotated; in-phase part gives their phase difference.
// - First-order Gardner loop finds symbol centres and zero crossings.
// - Differential-phase signal lag of 1.5 quarter-symbols is compensated.
// - Timing loop input lag of half a symbol is compensated.
// - Ten-sample noise filter delay is compensated with the other lags.
// - Symbol strobe coincides with peak phase of the resampled signal.
// - Per symbol, correlate received samples with conjugate of ideal signal.
// - Reference phases held per bit pair at four samples per symbol.
// - Detector rotates and sums partials over three symbols, 16 hypotheses.
// - 16 magnitudes leave as branch metrics for the trellis decoder.
// - Frequency loop uses corrected samples spaced one symbol apart.
// - Frequency loop de-rotates one by the other, in-phase part as measure.
// - Symbol-spaced phase difference averaged over 1024 symbols.
// - Scaled average accumulated into NCO frequency word.
// - Everything runs on one processing clock.
`timescale 1ns/1ns
module pdt_core (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire pdt_pkg::pdt_iq_s sample_in,
	input wire logic sample_valid_in,
	output logic sample_ready_out,
	output logic recovered_symbol_strobe_out,
	output logic signed [11:0] resampled_inphase_out,
	output logic signed [11:0] resampled_quadrature_out,
	output pdt_pkg::pdt_metric_s metric_out,
	output logic metric_valid_out,
	output logic signed [31:0] nco_freq_out
);
	// ==========================================
	// Declarations
	logic [pdt_pkg::FIFO_W-1:0] fifo_raw;
	pdt_pkg::pdt_iq_s fifo_iq;
	logic fifo_valid;
	logic emit_busy;
	logic take;
	logic took;
	logic [31:0] nco_phase;
	pdt_pkg::pdt_iq_s nco_iq;
	pdt_pkg::pdt_cplx_s cor_c;
	pdt_pkg::pdt_iq_s xc;
	pdt_pkg::pdt_iq_s xh [5];
	pdt_pkg::pdt_cplx_s tdiff_c;
	pdt_pkg::pdt_cplx_s adiff_c;
	logic signed [15:0] sample_phase_diff;
	logic signed [15:0] afc_symbol_phase_diff;
	logic signed [15:0] pd_h [3];
	logic signed [17:0] timing_loop_input;
	logic signed [17:0] yh [5];
	logic [1:0] k;
	logic [1:0] step;
	logic [2:0] k_sum;
	logic sym_end;
	logic strobe_now;
	logic signed [18:0] ted_d;
	logic signed [36:0] ted_p;
	logic signed [23:0] ted_s;
	logic signed [23:0] ted_acc;
	logic signed [23:0] next_acc;
	logic [1:0] next_step;
	pdt_pkg::pdt_cplx_s mf_c [pdt_pkg::NUM_PART];
	pdt_pkg::pdt_acc_s part_acc [pdt_pkg::NUM_PART];
	pdt_pkg::pdt_acc_s p0 [pdt_pkg::NUM_PART];
	pdt_pkg::pdt_acc_s p1 [pdt_pkg::NUM_PART];
	pdt_pkg::pdt_acc_s p2 [pdt_pkg::NUM_PART];
	logic sym_done;
	logic [pdt_pkg::MW-1:0] hyp_mag [pdt_pkg::NUM_HYP];
	logic [pdt_pkg::MW-1:0] metric_mag [pdt_pkg::NUM_HYP];
	logic [3:0] emit_cnt;
	logic signed [25:0] afc_sum;
	logic signed [25:0] afc_total;
	logic [9:0] afc_n;
	logic signed [31:0] afc_freq;

	// ==========================================
	// Input buffer
	pdt_fifo #(
		.W(pdt_pkg::FIFO_W),
		.D(pdt_pkg::FIFO_D)
	) u_fifo (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.ce_in(clk_en_in),
		.in_data_in(sample_in),
		.in_valid_in(sample_valid_in),
		.in_ready_out(sample_ready_out),
		.out_data_out(fifo_raw),
		.out_valid_out(fifo_valid),
		.out_ready_in(~emit_busy)
	);

	assign fifo_iq = pdt_pkg::pdt_iq_s'(fifo_raw);
	// Stall intake while metrics are being emitted
	assign take = fifo_valid & ~emit_busy;

	// ==========================================
	// Frequency correction
	assign nco_iq.i = pdt_pkg::COS_TBL[nco_phase[31:28]];
	assign nco_iq.q = pdt_pkg::COS_TBL[nco_phase[31:28] - pdt_pkg::SIN_OFS];

	pdt_derot u_nco_derot (
		.a_in(fifo_iq),
		.b_in(nco_iq),
		.y_out(cor_c)
	);

	assign xc.i = cor_c.re[12:1];
	assign xc.q = cor_c.im[12:1];

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			nco_phase <= '0;
		else if (clk_en_in && take)
			nco_phase <= nco_phase + afc_freq;
	end

	// Sample history, newest first
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			took <= 1'b0;
			for (int n = 0; n < 5; n++)
				xh[n] <= '0;
		end
		else if (clk_en_in)
		begin
			took <= take;
			if (take)
			begin
				xh[0] <= xc;
				for (int n = 1; n < 5; n++)
					xh[n] <= xh[n-1];
			end
		end
	end

	// ==========================================
	// Phase differences
	pdt_derot u_tdiff (
		.a_in(xh[0]),
		.b_in(pdt_pkg::pdt_jrot(xh[1])),
		.y_out(tdiff_c)
	);

	pdt_derot u_adiff (
		.a_in(xh[0]),
		.b_in(pdt_pkg::pdt_jrot(xh[4])),
		.y_out(adiff_c)
	);

	assign sample_phase_diff = tdiff_c.re;
	assign afc_symbol_phase_diff = adiff_c.re;

	// ==========================================
	// Symbol timing loop
	assign timing_loop_input = 18'(sample_phase_diff) + 18'(pd_h[0])
		+ 18'(pd_h[1]) + 18'(pd_h[2]);
	assign k_sum = {1'b0, k} + {1'b0, step};
	assign sym_end = took & k_sum[2];
	// Lags folded into the strobe phase
	assign strobe_now = took & (k == pdt_pkg::STROBE_PHASE);
	assign ted_d = 19'(yh[0]) - 19'(yh[4]);
	assign ted_p = 37'(yh[2] * ted_d);
	assign ted_s = 24'(ted_p >>> pdt_pkg::TED_SHIFT);

	always_comb
	begin
		next_acc = ted_acc + ted_s;
		next_step = 2'h1;
		if (next_acc > pdt_pkg::TED_THR)
		begin
			next_acc = next_acc - pdt_pkg::TED_THR;
			next_step = 2'h2;
		end
		else if (next_acc < -pdt_pkg::TED_THR)
		begin
			next_acc = next_acc + pdt_pkg::TED_THR;
			next_step = 2'h0;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			for (int n = 0; n < 3; n++)
				pd_h[n] <= '0;
			for (int n = 0; n < 5; n++)
				yh[n] <= '0;
		end
		else if (clk_en_in && took)
		begin
			pd_h[0] <= sample_phase_diff;
			pd_h[1] <= pd_h[0];
			pd_h[2] <= pd_h[1];
			yh[0] <= timing_loop_input;
			for (int n = 1; n < 5; n++)
				yh[n] <= yh[n-1];
		end
	end

	// First-order loop: the error only slips the sample phase
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			k <= '0;
			step <= 2'h1;
			ted_acc <= '0;
		end
		else if (clk_en_in && took)
		begin
			k <= k_sum[1:0];
			step <= 2'h1;
			if (strobe_now)
			begin
				ted_acc <= next_acc;
				step <= next_step;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			recovered_symbol_strobe_out <= 1'b0;
			resampled_inphase_out <= '0;
			resampled_quadrature_out <= '0;
		end
		else if (clk_en_in)
		begin
			recovered_symbol_strobe_out <= strobe_now;
			if (strobe_now)
			begin
				resampled_inphase_out <= xh[0].i;
				resampled_quadrature_out <= xh[0].q;
			end
		end
	end

	// ==========================================
	// Partial matched filter, one per bit pair
	generate
		for (genvar h = 0; h < pdt_pkg::NUM_PART; h++)
		begin : g_part
			pdt_pkg::pdt_iq_s ref_iq;
			logic [3:0] ang;

			// Reference phase ramps by +pi/8 per sample for h=3, -pi/8 for h=0; h=1 and 2 hold phase 0
			always_comb
			begin
				ang = 4'h0;
				if (h == 3)
					ang = {2'b00, k};
				else if (h == 0)
					ang = 4'h0 - {2'b00, k};
			end

			assign ref_iq.i = pdt_pkg::COS_TBL[ang];
			assign ref_iq.q = pdt_pkg::COS_TBL[ang - pdt_pkg::SIN_OFS];

			pdt_derot u_mf (
				.a_in(xh[0]),
				.b_in(ref_iq),
				.y_out(mf_c[h])
			);

			always_ff @(posedge ref_clk_in)
			begin
				if (sys_rst_in)
				begin
					part_acc[h] <= '0;
					p0[h] <= '0;
					p1[h] <= '0;
					p2[h] <= '0;
				end
				else if (clk_en_in && took)
				begin
					if (sym_end)
					begin
						part_acc[h] <= '0;
						p0[h].re <= part_acc[h].re + 20'(mf_c[h].re);
						p0[h].im <= part_acc[h].im + 20'(mf_c[h].im);
						p1[h] <= p0[h];
						p2[h] <= p1[h];
					end
					else
					begin
						part_acc[h].re <= part_acc[h].re + 20'(mf_c[h].re);
						part_acc[h].im <= part_acc[h].im + 20'(mf_c[h].im);
					end
				end
			end
		end
	endgenerate

	// ==========================================
	// Three-symbol detector, oldest bit in b[3]
	generate
		for (genvar b = 0; b < pdt_pkg::NUM_HYP; b++)
		begin : g_hyp
			localparam logic [3:0] BV = 4'(b);
			logic [1:0] q_old;
			logic [1:0] q_mid;
			pdt_pkg::pdt_acc_s r1;
			pdt_pkg::pdt_acc_s r0;
			logic signed [21:0] s_re;
			logic signed [21:0] s_im;
			logic [21:0] a_re;
			logic [21:0] a_im;

			assign q_old = pdt_pkg::pdt_qturn(BV[3:2]);
			assign q_mid = pdt_pkg::pdt_qturn(BV[2:1]);
			assign r1 = pdt_pkg::pdt_qrot(p1[BV[2:1]], 2'h0 - q_old);
			assign r0 = pdt_pkg::pdt_qrot(p0[BV[1:0]], 2'h0 - q_old - q_mid);
			assign s_re = 22'(p2[BV[3:2]].re) + 22'(r1.re) + 22'(r0.re);
			assign s_im = 22'(p2[BV[3:2]].im) + 22'(r1.im) + 22'(r0.im);
			assign a_re = s_re[21] ? 22'(-s_re) : 22'(s_re);
			assign a_im = s_im[21] ? 22'(-s_im) : 22'(s_im);
			assign hyp_mag[b] = 24'(a_re) + 24'(a_im);
		end
	endgenerate

	// ==========================================
	// Branch metric emission
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			sym_done <= 1'b0;
		else if (clk_en_in)
			sym_done <= sym_end;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			emit_busy <= 1'b0;
			emit_cnt <= '0;
			for (int n = 0; n < pdt_pkg::NUM_HYP; n++)
				metric_mag[n] <= '0;
		end
		else if (clk_en_in)
		begin
			if (sym_done)
			begin
				emit_busy <= 1'b1;
				emit_cnt <= '0;
				for (int n = 0; n < pdt_pkg::NUM_HYP; n++)
					metric_mag[n] <= hyp_mag[n];
			end
			else if (emit_busy)
			begin
				emit_cnt <= emit_cnt + 1'b1;
				if (emit_cnt == 4'hf)
					emit_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			metric_valid_out <= 1'b0;
			metric_out <= '0;
		end
		else if (clk_en_in)
		begin
			metric_valid_out <= emit_busy;
			metric_out.hyp <= emit_cnt;
			metric_out.mag <= metric_mag[emit_cnt];
		end
	end

	// ==========================================
	// Frequency control loop
	assign afc_total = afc_sum + 26'(afc_symbol_phase_diff);

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			afc_sum <= '0;
			afc_n <= '0;
			afc_freq <= '0;
			nco_freq_out <= '0;
		end
		else if (clk_en_in)
		begin
			nco_freq_out <= afc_freq;
			if (sym_end)
			begin
				afc_n <= afc_n + 1'b1;
				if (afc_n == pdt_pkg::AFC_LAST)
				begin
					afc_sum <= '0;
					afc_freq <= afc_freq + 32'(afc_total >>> pdt_pkg::AFC_SHIFT);
				end
				else
					afc_sum <= afc_total;
			end
		end
	end
	// Single clock throughout
endmodule

// file: dv/pdt_core_asserts.sv
// Port-level checks of the demodulation core.
// Assumes it is bound to pdt_core; one clock domain.
`timescale 1ns/1ns
module pdt_core_asserts (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic sample_ready_out,
	input wire logic recovered_symbol_strobe_out,
	input wire logic signed [11:0] resampled_inphase_out,
	input wire logic signed [11:0] resampled_quadrature_out,
	input wire pdt_pkg::pdt_metric_s metric_out,
	input wire logic metric_valid_out,
	input wire logic signed [31:0] nco_freq_out
);
	// ==========================================
	// Helper counters
	logic [3:0] hcnt;
	logic [15:0] gap;
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || !metric_valid_out)
			hcnt <= 4'h0;
		else if (clk_en_in)
			hcnt <= hcnt + 4'h1;
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || $changed(nco_freq_out))
			gap <= 16'h0000;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end

	// ==========================================
	// Properties
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_release;
		sys_rst_in ##1 !sys_rst_in;
	endsequence
	sequence s_burst_end;
		metric_valid_out ##1 !metric_valid_out;
	endsequence

	AST_RST_CLEAR: assert property (disable iff (1'b0) sys_rst_in |=> !sample_ready_out
		&& !metric_valid_out && !recovered_symbol_strobe_out && nco_freq_out == 32'h0)
		else $error("outputs not cleared by reset");
	AST_READY_UP: assert property (disable iff (1'b0) s_release ##0 clk_en_in
		|-> ##[1:2] sample_ready_out) else $error("ready late after reset");
	AST_STROBE_PULSE: assert property (recovered_symbol_strobe_out && clk_en_in
		|=> !recovered_symbol_strobe_out) else $error("strobe longer than one cycle");
	AST_RESAMP_HOLD: assert property (!recovered_symbol_strobe_out |->
		$stable(resampled_inphase_out) && $stable(resampled_quadrature_out))
		else $error("resampled value moved off strobe");
	AST_HYP_ORDER: assert property (metric_valid_out |-> metric_out.hyp == hcnt)
		else $error("hypothesis out of order");
	AST_BURST_16: assert property (s_burst_end |-> $past(metric_out.hyp) == 4'hf)
		else $error("metric burst not 16 long");
	AST_FREEZE: assert property (!clk_en_in |=> $stable(nco_freq_out)
		&& $stable(metric_out) && $stable(recovered_symbol_strobe_out)
		&& $stable(sample_ready_out)) else $error("state moved while disabled");
	AST_NCO_GAP: assert property ($changed(nco_freq_out) |-> gap >= 16'h0800)
		else $error("frequency word updated too often");
endmodule

// file: dv/pdt_src.sv
// Upstream front end model: offers baseband samples back to back.
// Assumes the sink takes a word on an enabled edge with valid and ready.
`timescale 1ns/1ns
module pdt_src (
	input wire logic clk_in,
	input wire logic ce_in,
	input wire logic en_in,
	input wire logic rot_in,
	input wire logic ready_in,
	output pdt_pkg::pdt_iq_s sample_out,
	output logic valid_out,
	output int taken_out
);
	logic [3:0] idx;
	initial
	begin
		idx = 4'h0;
		valid_out = 1'b0;
		sample_out = '0;
		taken_out = 0;
	end
	// Held until taken, then next phase step of pi/8
	always @(posedge clk_in)
	begin
		if (ce_in && valid_out && ready_in)
		begin
			idx = idx + 4'h1;
			taken_out++;
		end
		#1;
		if (en_in)
		begin
			valid_out = 1'b1;
			sample_out.i = rot_in ? pdt_pkg::COS_TBL[idx] : 12'h000;
			sample_out.q = rot_in ? pdt_pkg::COS_TBL[4'(idx - pdt_pkg::SIN_OFS)] : 12'h000;
		end
		else
		begin
			valid_out = 1'b0;
			sample_out = ~sample_out;
		end
	end
endmodule

// file: dv/pdt_core_tb.sv
// Self-checking bench of the demodulation core.
// Assumes pdt_src feeds the core and pdt_core_asserts is bound to it.
`timescale 1ns/1ns
module pdt_core_tb;
	logic clk, rst, ce, en, rot, ready, strobe, mvalid;
	logic signed [11:0] ri, rq;
	logic signed [31:0] nco;
	pdt_pkg::pdt_iq_s smp;
	pdt_pkg::pdt_metric_s met;
	logic svalid;
	int taken, miscompares, compares, nstrobe, nburst, nzmag, nfull;

	pdt_src u_src (.clk_in(clk), .ce_in(ce), .en_in(en), .rot_in(rot), .ready_in(ready),
		.sample_out(smp), .valid_out(svalid), .taken_out(taken));
	pdt_core DUT (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce), .sample_in(smp),
		.sample_valid_in(svalid), .sample_ready_out(ready),
		.recovered_symbol_strobe_out(strobe), .resampled_inphase_out(ri),
		.resampled_quadrature_out(rq), .metric_out(met), .metric_valid_out(mvalid),
		.nco_freq_out(nco));

	// ==========================================
	// Clock, monitor, checks
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (!rst && ce)
		begin
			nstrobe += (strobe === 1'b1);
			nburst += (mvalid === 1'b1 && met.hyp === 4'hf);
			nzmag += (mvalid === 1'b1 && met.mag !== 24'h0);
			nfull += (svalid && ready === 1'b0);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s got %h", $time, what, got);
		end
	endtask
	task automatic chk_in(input int got, input int lo, input int hi, input string what);
		compares++;
		if (got < lo || got > hi)
		begin
			miscompares++;
			$display("BAD %0t %s got %0d", $time, what, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_bursts(input int n);
		int s;
		s = nburst;
		while (nburst - s < n)
			step(1);
	endtask
	task automatic conclude;
		$display("miscompares %0d compares %0d", miscompares, compares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		rst = 1'b1;
		step(8);
		chk({ready, mvalid, strobe}, 32'h0, "flags in reset");
		chk(nco, 32'h0, "nco in reset");
		rst = 1'b0;
		step(3);
		chk(ready, 32'h1, "ready after reset");
	endtask
	task automatic t_zero;
		int z0;
		z0 = nzmag;
		rot = 1'b0;
		en = 1'b1;
		wait_bursts(1040);
		chk(nco, 32'h0, "nco with no offset");
		chk_in(nzmag - z0, 0, 0, "metric of silence");
		chk({ri, rq}, 32'h0, "resampled silence");
		en = 1'b0;
	endtask
	task automatic t_freeze;
		logic [31:0] n0;
		logic [31:0] m0;
		rot = 1'b1;
		en = 1'b1;
		step(60);
		ce = 1'b0;
		n0 = nco;
		m0 = {3'h0, mvalid, met};
		step(20);
		chk(nco, n0, "nco frozen");
		chk({3'h0, mvalid, met}, m0, "metric frozen");
		ce = 1'b1;
		en = 1'b0;
	endtask
	task automatic t_rot;
		int t0, s0, b0, z0, f0, c;
		t_reset();
		t0 = taken;
		s0 = nstrobe;
		b0 = nburst;
		z0 = nzmag;
		f0 = nfull;
		rot = 1'b1;
		en = 1'b1;
		wait_bursts(1000);
		chk(nco, 32'h0, "nco before average ends");
		wait_bursts(40);
		chk(nco > 32'sh0, 32'h1, "nco follows offset");
		// Samples still queued in the full FIFO have not reached the timing loop
		c = (taken - t0 - pdt_pkg::FIFO_D) / pdt_pkg::SPS;
		chk_in(nstrobe - s0, c - 4, c + 4, "strobes");
		chk(ri != 12'sh000 || rq != 12'sh000, 32'h1, "resampled tone");
		chk_in(nburst - b0, nstrobe - s0 - 2, nstrobe - s0 + 2, "bursts");
		chk(nzmag - z0 > 0, 32'h1, "metric of tone");
		chk(nfull - f0 > 0, 32'h1, "intake refused when full");
		en = 1'b0;
	endtask

	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		en = 1'b0;
		rot = 1'b0;
		miscompares = 0;
		compares = 0;
		nstrobe = 0;
		nburst = 0;
		nzmag = 0;
		nfull = 0;
		t_reset();
		t_zero();
		t_freeze();
		t_rot();
		conclude();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		conclude();
	end
endmodule

bind pdt_core pdt_core_asserts u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
	.clk_en_in(clk_en_in), .sample_ready_out(sample_ready_out),
	.recovered_symbol_strobe_out(recovered_symbol_strobe_out),
	.resampled_inphase_out(resampled_inphase_out),
	.resampled_quadrature_out(resampled_quadrature_out), .metric_out(metric_out),
	.metric_valid_out(metric_valid_out), .nco_freq_out(nco_freq_out));
